// *** rtl/bus_region_access_guard.sv ***
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "guard_defs.svh"

// How it works
// - sixteen region descriptors of four words each hold bounds and rights.
// - a region spans start to end granule, 32 bytes up to the whole 4 GB.
// - out of reset checking is off and every access passes.
// - the core master has separate read, write, execute rights per mode.
// - other masters have read and write rights only.
// - writing a bound clears the region valid bit in hardware.
// - the alternate view rewrites only the access word.
// - any matching region that grants wins over those that deny.
// - the memory port and the bridge port are checked side by side.
// - no hit, or no granting hit, is a protection error.
// - an error gives an error answer and nothing goes to the target.
// - each port keeps a 64-bit capture of its last faulting access.
// - permitted accesses go to the target with no error.
module bus_region_access_guard #(
  parameter int NREG = `NREG_DFLT
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  output logic      [31:0] REG_RDATA,
  // memory port request
  input  wire logic        SR_VALID,
  input  wire logic [31:0] SR_ADDR,
  input  wire logic        SR_WRITE,
  input  wire logic        SR_EXEC,
  input  wire logic        SR_SUPER,
  input  wire logic [1:0]  SR_MID,
  // memory port answer
  output logic             SR_FWD,
  output logic      [31:0] SR_FWD_ADDR,
  output logic             SR_FWD_WRITE,
  output logic             SR_ERR,
  // bridge port request
  input  wire logic        PB_VALID,
  input  wire logic [31:0] PB_ADDR,
  input  wire logic        PB_WRITE,
  input  wire logic        PB_EXEC,
  input  wire logic        PB_SUPER,
  input  wire logic [1:0]  PB_MID,
  // bridge port answer
  output logic             PB_FWD,
  output logic      [31:0] PB_FWD_ADDR,
  output logic             PB_FWD_WRITE,
  output logic             PB_ERR,
  // interrupt
  output logic             IRQ
);

  // ==========================================
  // rights lookup

  // rights of one access against one access word
  function automatic logic perm_ok(
    input guard_pkg::word_t acc,
    input guard_pkg::mid_t  mid,
    input logic             wr,
    input logic             ex,
    input logic             sup
  );
    logic [2:0] rwx;
    logic [1:0] rw;
    begin
      rwx = sup ? acc[`AC_SUP +: 3] : acc[`AC_USR +: 3];
      rw  = acc[(`AC_OTH + 2 * int'(mid)) +: 2];
      if (mid == `CORE_MID)
        perm_ok = ex ? rwx[2] : (wr ? rwx[1] : rwx[0]);
      else
        perm_ok = wr ? rw[1] : rw[0];
    end
  endfunction

  // ==========================================
  // state

  logic             en_r;
  logic [1:0]       stat_r;
  logic [1:0]       stat_nxt;
  logic [1:0]       mask_r;
  logic             irq_r;
  logic [31:0]      rdata_r;
  logic [31:0]      rd_mux;
  guard_pkg::gran_t start_r [NREG];
  guard_pkg::gran_t end_r   [NREG];
  guard_pkg::word_t acc_r   [NREG];
  logic             vld_r   [NREG];

  // per port request and answer
  logic             p_vld   [2];
  logic             p_wr    [2];
  logic             p_ex    [2];
  logic             p_sup   [2];
  guard_pkg::mid_t  p_mid   [2];
  guard_pkg::word_t p_addr  [2];
  logic [NREG-1:0]  hit_v   [2];
  logic [NREG-1:0]  grant_v [2];
  logic             deny    [2];
  logic             pass    [2];
  logic             fwd_r   [2];
  logic             fwdw_r  [2];
  logic             err_r   [2];
  guard_pkg::word_t fwda_r  [2];
  guard_pkg::word_t ecap_a_r[2];
  guard_pkg::word_t ecap_d_r[2];

  // ==========================================
  // register decode

  logic       desc_wr;
  logic       alt_wr;
  logic       alt_sel;
  logic       desc_sel;
  logic       err_sel;
  logic       stat_rd;
  logic [3:0] d_idx;
  logic [1:0] d_wd;
  logic [3:0] a_idx;

  // address fields and strobes
  assign desc_sel = REG_ADDR[11:8] == `PG_DESC;
  assign alt_sel  = REG_ADDR[11:8] == `PG_ALT && REG_ADDR[7:6] == 2'h0;
  assign err_sel  = REG_ADDR[11:4] == `PG_ERR;
  assign desc_wr  = REG_WE && desc_sel;
  assign alt_wr   = REG_WE && alt_sel;
  assign stat_rd  = REG_RE && REG_ADDR == `RG_STAT;
  assign d_idx    = REG_ADDR[7:4];
  assign d_wd     = REG_ADDR[3:2];
  assign a_idx    = REG_ADDR[5:2];

  // ==========================================
  // descriptors

  genvar r;
  generate
    for (r = 0; r < NREG; r++)
    begin : g_reg
      always_ff @(posedge CORE_CLK)
      begin
        if (RST)
        begin
          start_r[r] <= `GRAN_RST;
          end_r[r]   <= `GRAN_RST;
          acc_r[r]   <= `WORD_RST;
          vld_r[r]   <= 1'b0;
        end
        else if (desc_wr && d_idx == 4'(r))
        begin
          case (d_wd)
            `DW_START:
            begin
              start_r[r] <= REG_WDATA[31:`GRAN_LSB];
              vld_r[r]   <= 1'b0;
            end
            `DW_END:
            begin
              end_r[r] <= REG_WDATA[31:`GRAN_LSB];
              vld_r[r] <= 1'b0;
            end
            `DW_ACC:
              acc_r[r] <= REG_WDATA;
            default:
              vld_r[r] <= REG_WDATA[`VLD_BIT];
          endcase
        end
        else if (alt_wr && a_idx == 4'(r))
          acc_r[r] <= REG_WDATA;
      end
    end
  endgenerate

  // ==========================================
  // port checks

  // request pins gathered per port
  assign p_vld[0]  = SR_VALID;
  assign p_wr[0]   = SR_WRITE;
  assign p_ex[0]   = SR_EXEC;
  assign p_sup[0]  = SR_SUPER;
  assign p_mid[0]  = SR_MID;
  assign p_addr[0] = SR_ADDR;
  assign p_vld[1]  = PB_VALID;
  assign p_wr[1]   = PB_WRITE;
  assign p_ex[1]   = PB_EXEC;
  assign p_sup[1]  = PB_SUPER;
  assign p_mid[1]  = PB_MID;
  assign p_addr[1] = PB_ADDR;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_port
      for (r = 0; r < NREG; r++)
      begin : g_hit
        assign hit_v[g][r] = vld_r[r]
          && p_addr[g][31:`GRAN_LSB] >= start_r[r]
          && p_addr[g][31:`GRAN_LSB] <= end_r[r];
        assign grant_v[g][r] = hit_v[g][r]
          && perm_ok(acc_r[r], p_mid[g], p_wr[g], p_ex[g], p_sup[g]);
      end

      assign deny[g] = en_r && p_vld[g] && ~|grant_v[g];
      assign pass[g] = p_vld[g] && !deny[g];

      always_ff @(posedge CORE_CLK)
      begin
        if (RST)
        begin
          fwd_r[g]  <= 1'b0;
          err_r[g]  <= 1'b0;
          fwdw_r[g] <= 1'b0;
          fwda_r[g] <= `WORD_RST;
        end
        else
        begin
          fwd_r[g]  <= pass[g];
          err_r[g]  <= deny[g];
          fwdw_r[g] <= pass[g] && p_wr[g];
          fwda_r[g] <= pass[g] ? p_addr[g] : `WORD_RST;
        end
      end

      always_ff @(posedge CORE_CLK)
      begin
        if (RST)
        begin
          ecap_a_r[g] <= `WORD_RST;
          ecap_d_r[g] <= `WORD_RST;
        end
        else if (deny[g])
        begin
          ecap_a_r[g] <= p_addr[g];
          ecap_d_r[g] <= `WORD_RST;
          ecap_d_r[g][`DT_MID +: 2]     <= p_mid[g];
          ecap_d_r[g][`DT_WR]           <= p_wr[g];
          ecap_d_r[g][`DT_SUP]          <= p_sup[g];
          ecap_d_r[g][`DT_EX]           <= p_ex[g];
          ecap_d_r[g][`DT_HIT +: NREG]  <= hit_v[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // control, status, interrupt

  // sticky fault flags, set wins over read clear
  assign stat_nxt = (stat_rd ? 2'h0 : stat_r) | {deny[1], deny[0]};

  // control registers and interrupt level
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      en_r   <= 1'b0;
      mask_r <= 2'h0;
      stat_r <= 2'h0;
      irq_r  <= 1'b0;
    end
    else
    begin
      if (REG_WE && REG_ADDR == `RG_CTRL)
        en_r <= REG_WDATA[`EN_BIT];
      if (REG_WE && REG_ADDR == `RG_MASK)
        mask_r <= REG_WDATA[1:0];
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  // ==========================================
  // read path

  // read data select
  always_comb
  begin
    rd_mux = `WORD_RST;
    if (REG_ADDR == `RG_CTRL)
      rd_mux[`EN_BIT] = en_r;
    else if (REG_ADDR == `RG_STAT)
      rd_mux[1:0] = stat_r;
    else if (REG_ADDR == `RG_MASK)
      rd_mux[1:0] = mask_r;
    else if (err_sel && REG_ADDR[1:0] == 2'h0)
      rd_mux = REG_ADDR[2] ? ecap_d_r[REG_ADDR[3]] : ecap_a_r[REG_ADDR[3]];
    else if (desc_sel && int'(d_idx) < NREG)
    begin
      case (d_wd)
        `DW_START: rd_mux[31:`GRAN_LSB] = start_r[d_idx];
        `DW_END:   rd_mux[31:`GRAN_LSB] = end_r[d_idx];
        `DW_ACC:   rd_mux = acc_r[d_idx];
        default:   rd_mux[`VLD_BIT] = vld_r[d_idx];
      endcase
    end
    else if (alt_sel && int'(a_idx) < NREG)
      rd_mux = acc_r[a_idx];
  end

  // read data one cycle after strobe
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      rdata_r <= `WORD_RST;
    else
      rdata_r <= REG_RE ? rd_mux : `WORD_RST;
  end

  // outputs from flops
  assign REG_RDATA    = rdata_r;
  assign SR_FWD       = fwd_r[0];
  assign SR_FWD_ADDR  = fwda_r[0];
  assign SR_FWD_WRITE = fwdw_r[0];
  assign SR_ERR       = err_r[0];
  assign PB_FWD       = fwd_r[1];
  assign PB_FWD_ADDR  = fwda_r[1];
  assign PB_FWD_WRITE = fwdw_r[1];
  assign PB_ERR       = err_r[1];
  assign IRQ          = irq_r;

  // ==========================================
  // checks

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence s_fault0;
    deny[0] && mask_r[0];
  endsequence

  sequence s_flagged0;
    stat_r[0] && IRQ;
  endsequence

  chk_open_pass:
    assert property (!en_r && SR_VALID |=> SR_FWD && !SR_ERR)
    else $error("disabled guard blocked an access");

  chk_err_blocks:
    assert property ((SR_ERR |-> !SR_FWD && !SR_FWD_WRITE) and (PB_ERR |-> !PB_FWD && !PB_FWD_WRITE))
    else $error("error answer with forward");

  chk_deny_cause:
    assert property (en_r && PB_VALID && grant_v[1] == '0 |=> PB_ERR && !PB_FWD)
    else $error("ungranted access not flagged");

  chk_grant_pass:
    assert property (SR_VALID && grant_v[0] != '0 |=> SR_FWD && !SR_ERR
      && SR_FWD_ADDR == $past(SR_ADDR))
    else $error("granted access not forwarded");

  chk_cap_addr:
    assert property (deny[1] |=> ecap_a_r[1] == $past(PB_ADDR))
    else $error("fault address not captured");

  chk_cap_detail:
    assert property (deny[0] |=> ecap_d_r[0][`DT_MID +: 2] == $past(SR_MID)
      && ecap_d_r[0][`DT_WR] == $past(SR_WRITE))
    else $error("fault detail not captured");

  chk_valid_clear:
    assert property (desc_wr && d_idx == 4'h0 && d_wd == `DW_START |=> !vld_r[0])
    else $error("valid kept after bound write");

  chk_alt_bounds:
    assert property (alt_wr && a_idx == 4'h0 |=> $stable(start_r[0])
      && $stable(end_r[0]) && acc_r[0] == $past(REG_WDATA))
    else $error("alternate write disturbed bounds");

  chk_both_ports:
    assert property (deny[0] && deny[1] |=> SR_ERR && PB_ERR)
    else $error("ports not checked together");

  // unmasked fault raises interrupt
  chk_irq_raise:
    assert property (s_fault0 |=> s_flagged0)
    else $error("fault did not raise interrupt");

endmodule

// *** rtl/guard_defs.svh ***
`ifndef GUARD_DEFS_SVH
`define GUARD_DEFS_SVH
// ==========================================
// register map, byte addresses
`define RG_CTRL   12'h000
`define RG_STAT   12'h004
`define RG_MASK   12'h008
`define PG_ERR    8'h01
`define PG_DESC   4'h4
`define PG_ALT    4'h8
// ==========================================
// descriptor word select
`define DW_START  2'h0
`define DW_END    2'h1
`define DW_ACC    2'h2
`define DW_VLD    2'h3
// ==========================================
// field positions
`define GRAN_LSB  5
`define EN_BIT    0
`define VLD_BIT   0
`define AC_SUP    0
`define AC_USR    3
`define AC_OTH    4
`define DT_MID    0
`define DT_WR     2
`define DT_SUP    3
`define DT_EX     4
`define DT_HIT    16
// ==========================================
// counts and reset values
`define NREG_DFLT 16
`define CORE_MID  2'h0
`define WORD_RST  32'h0000_0000
`define GRAN_RST  27'h000_0000
`endif

// *** rtl/guard_pkg.sv ***
// ==========================================
// shared types
package guard_pkg;
  typedef logic [31:0] word_t;
  typedef logic [26:0] gran_t;
  typedef logic [1:0]  mid_t;
endpackage

// *** tb/target_model.sv ***
`timescale 1ns/1ps
// ==========================================
// guarded slave target, tallies what reaches it
module target_model (
  // clock
  input  wire logic        clk,
  // forwarded cycle
  input  wire logic        fwd,
  input  wire logic [31:0] fwd_addr,
  input  wire logic        fwd_write,
  // tally
  output int               hits,
  output logic      [31:0] last_addr,
  output logic             last_write
);
  initial hits = 0;
  // take each cycle let through; a blocked one never shows here
  always @(posedge clk)
  begin
    if (fwd === 1'b1)
    begin
      hits       <= hits + 1;
      last_addr  <= fwd_addr;
      last_write <= fwd_write;
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "guard_defs.svh"
module tb;
  // ==========================================
  // stimulus and observation
  typedef struct packed {
    logic        p;
    logic [31:0] ad;
    logic        wr;
    logic        ex;
    logic        sp;
    logic [1:0]  mid;
    logic        bad;
    logic [15:0] hit;
  } row_t;
  logic        clk, rst, we, re, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic        v[2], w[2], x[2], s[2], fwd[2], fw[2], err[2], lw[2];
  logic [31:0] a[2], fa[2], la[2];
  logic [1:0]  m[2];
  int          hits[2];
  int          nfwd[2] = '{0, 0};
  int          failures = 0;
  int          n_compared = 0;
  row_t        t;
  row_t        rows[13] = '{
    '{1'b0, 32'h2000_0000, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 16'h0000},
    '{1'b0, 32'h2000_0004, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0001},
    '{1'b0, 32'h2000_0800, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0000},
    '{1'b1, 32'h2000_0FFC, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 16'h0003},
    '{1'b1, 32'h2000_1000, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 16'h0000},
    '{1'b0, 32'h2000_001F, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 16'h0000},
    '{1'b0, 32'h2000_0020, 1'b1, 1'b0, 1'b0, 2'h1, 1'b1, 16'h0001},
    '{1'b1, 32'hFFFF_FFFC, 1'b1, 1'b0, 1'b0, 2'h3, 1'b0, 16'h0000},
    '{1'b1, 32'hC000_0000, 1'b1, 1'b0, 1'b0, 2'h2, 1'b1, 16'h8000},
    '{1'b0, 32'h1FFF_FFE0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 16'h0000},
    '{1'b0, 32'h2000_0000, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 16'h0000},
    '{1'b0, 32'h2000_0000, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0001},
    '{1'b1, 32'h2000_0FE0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 16'h0000}};

  // ==========================================
  // design and slave targets
  bus_region_access_guard uut (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .SR_VALID(v[0]), .SR_ADDR(a[0]),
    .SR_WRITE(w[0]), .SR_EXEC(x[0]), .SR_SUPER(s[0]), .SR_MID(m[0]), .SR_FWD(fwd[0]),
    .SR_FWD_ADDR(fa[0]), .SR_FWD_WRITE(fw[0]), .SR_ERR(err[0]), .PB_VALID(v[1]),
    .PB_ADDR(a[1]), .PB_WRITE(w[1]), .PB_EXEC(x[1]), .PB_SUPER(s[1]), .PB_MID(m[1]),
    .PB_FWD(fwd[1]), .PB_FWD_ADDR(fa[1]), .PB_FWD_WRITE(fw[1]), .PB_ERR(err[1]), .IRQ(irq));
  target_model tgt0 (.clk(clk), .fwd(fwd[0]), .fwd_addr(fa[0]), .fwd_write(fw[0]),
    .hits(hits[0]), .last_addr(la[0]), .last_write(lw[0]));
  target_model tgt1 (.clk(clk), .fwd(fwd[1]), .fwd_addr(fa[1]), .fwd_write(fw[1]),
    .hits(hits[1]), .last_addr(la[1]), .last_write(lw[1]));

  // ==========================================
  // bus tasks and checks
  task cmp(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(logic [11:0] ad, logic [31:0] d);
    addr  <= ad;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task rd(logic [11:0] ad, logic [31:0] e);
    addr <= ad;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 cmp("rdata", rdata, e);
    @(posedge clk);
  endtask
  task desc(logic [11:0] b, logic [31:0] st, logic [31:0] en, logic [31:0] ac);
    wr(b, st);
    wr(b + 12'h004, en);
    wr(b + 12'h008, ac);
    wr(b + 12'h00C, 32'h1);
  endtask
  task go(row_t r);
    v[r.p] <= 1'b1;
    a[r.p] <= r.ad;
    w[r.p] <= r.wr;
    x[r.p] <= r.ex;
    s[r.p] <= r.sp;
    m[r.p] <= r.mid;
  endtask
  task acc(row_t r);
    go(r);
    @(posedge clk);
    v[r.p] <= 1'b0;
    #1 cmp("err", 32'(err[r.p]), 32'(r.bad));
    cmp("fwd", 32'(fwd[r.p]), 32'(!r.bad));
    cmp("fwd_addr", fa[r.p], r.bad ? 32'h0 : r.ad);
    if (!r.bad)
      nfwd[r.p]++;
    @(posedge clk);
  endtask
  task fault(row_t r);
    logic [11:0] cb;
    cb = r.p ? 12'h018 : 12'h010;
    #1 cmp("irq", 32'(irq), 32'h1);
    @(posedge clk);
    rd(cb, r.ad);
    rd(cb + 12'h004, {r.hit, 11'h000, r.ex, r.sp, r.wr, r.mid});
    rd(`RG_STAT, r.p ? 32'h2 : 32'h1);
    rd(`RG_STAT, 32'h0);
    #1 cmp("irq", 32'(irq), 32'h0);
    @(posedge clk);
  endtask
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (6000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    end_sim();
  end

  // ==========================================
  // test sequence
  initial
  begin
    rst   = 1'b1;
    we    = 1'b0;
    re    = 1'b0;
    addr  = 12'h000;
    wdata = 32'h0;
    v     = '{1'b0, 1'b0};
    a     = '{32'h0, 32'h0};
    w     = '{1'b0, 1'b0};
    x     = '{1'b0, 1'b0};
    s     = '{1'b0, 1'b0};
    m     = '{2'h0, 2'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t = rows[9];
    t.bad = 1'b0;
    acc(t);
    desc(12'h400, 32'h2000_0000, 32'h2000_0FE0, 32'h0000_0043);
    desc(12'h410, 32'h2000_0800, 32'h2000_0FE0, 32'h0000_0018);
    desc(12'h4F0, 32'hC000_0000, 32'hFFFF_FFE0, 32'h0000_0801);
    rd(12'h4F8, 32'h0000_0801);
    wr(`RG_MASK, 32'h3);
    wr(`RG_CTRL, 32'h1);
    foreach (rows[i])
    begin
      acc(rows[i]);
      if (rows[i].bad)
        fault(rows[i]);
    end
    $display("test table done");
    // both ports fault in one cycle with the interrupt masked
    wr(`RG_MASK, 32'h0);
    go('{1'b0, 32'h1000_0000, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 16'h0});
    go('{1'b1, 32'h3000_0000, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0});
    @(posedge clk);
    v[0] <= 1'b0;
    v[1] <= 1'b0;
    #1 cmp("err pair", {30'h0, err[1], err[0]}, 32'h3);
    cmp("fwd pair", {30'h0, fwd[1], fwd[0]}, 32'h0);
    @(posedge clk);
    #1 cmp("irq", 32'(irq), 32'h0);
    @(posedge clk);
    rd(12'h018, 32'h3000_0000);
    rd(`RG_STAT, 32'h3);
    $display("test dual port done");
    // two faults back to back, the newer record wins
    wr(`RG_MASK, 32'h3);
    go(rows[9]);
    @(posedge clk);
    a[0] <= 32'h1000_0080;
    @(posedge clk);
    v[0] <= 1'b0;
    #1 cmp("err", 32'(err[0]), 32'h1);
    @(posedge clk);
    rd(12'h010, 32'h1000_0080);
    rd(`RG_STAT, 32'h1);
    $display("test overwrite done");
    // alternate view, then bound rewrite drops valid
    wr(12'h800, 32'h0000_005B);
    rd(12'h400, 32'h2000_0000);
    rd(12'h40C, 32'h1);
    t = rows[1];
    t.bad = 1'b0;
    acc(t);
    wr(12'h404, 32'h2000_0FE0);
    rd(12'h40C, 32'h0);
    t = rows[0];
    t.bad = 1'b1;
    acc(t);
    fault(t);
    wr(12'h40C, 32'h1);
    acc(rows[0]);
    rd(12'h0F0, 32'h0);
    $display("test descriptor views done");
    // reset in mid run reopens the guard
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`RG_CTRL, 32'h0);
    rd(12'h408, 32'h0);
    t = rows[11];
    t.bad = 1'b0;
    acc(t);
    #1 cmp("mem hits", 32'(hits[0]), 32'(nfwd[0]));
    cmp("mem last addr", la[0], 32'h2000_0000);
    cmp("mem last write", 32'(lw[0]), 32'h0);
    cmp("bridge last addr", la[1], 32'h2000_0FE0);
    cmp("bridge last write", 32'(lw[1]), 32'h1);
    cmp("bridge hits", 32'(hits[1]), 32'(nfwd[1]));
    $display("test reset done");
    end_sim();
  end
endmodule
